// ---- core/hwc_defs.vh ----
// Purpose: Shared constants of the hardware configuration block.
// Assumes: Included by bare name from every design file of the block.
// Notes: Offsets are byte addresses on the register bus.
`ifndef HWC_DEFS_VH
`define HWC_DEFS_VH

// ==========================================================================
// Register map
`define HWC_ADR_HARDWARE_CONFIGURATION 8'h14
`define HWC_ADR_STATUS 8'h40

// ==========================================================================
// Field positions of the configuration register
`define HWC_PROT_BIT 15
`define HWC_BOOST_HI 14
`define HWC_BOOST_LO 13
`define HWC_BIR_BIT 12
`define HWC_ACTIVITY_LED_FAST_BIT 11
`define HWC_RXOFF_HI 10
`define HWC_RXOFF_LO 9
`define HWC_SBP_BIT 8
`define HWC_IME_BIT 7
`define HWC_DRP_BIT 6

// ==========================================================================
// Reset values
`define HWC_PROT_RST 1'h0
`define HWC_BOOST_RST 2'h0
`define HWC_BIR_RST 1'h0
`define HWC_ACTIVITY_LED_FAST_RST 1'h0
`define HWC_RXOFF_RST 2'h0
`define HWC_SBP_RST 1'h0
`define HWC_IME_RST 1'h0
`define HWC_DRP_RST 1'h0

// ==========================================================================
// Drive boost percentages
`define HWC_BOOST_PCT0 4'h0
`define HWC_BOOST_PCT1 4'h4
`define HWC_BOOST_PCT2 4'h8
`define HWC_BOOST_PCT3 4'hC

// ==========================================================================
// Timing
`define HWC_CLK_HZ 50000000
`define HWC_LED_SLOW_MS 80
`define HWC_LED_FAST_US 15
`define HWC_LED_SLOW_CYC ((`HWC_CLK_HZ / 1000) * `HWC_LED_SLOW_MS)
`define HWC_LED_FAST_CYC ((`HWC_CLK_HZ / 1000000) * `HWC_LED_FAST_US)

// ==========================================================================
// Pins shared between visibility and the normal pin function
`define HWC_MII_PINS 9

`endif

// ---- core/hwc_led_timer.v ----
// Purpose: Activity LED pulse stretcher with a slow and a fast on/off time.
// Assumes: activity_i is a one-cycle event pulse.
// Notes: Activity seen during a blink is remembered and starts the next blink.
`include "hwc_defs.vh"

module hwc_led_timer #(
    parameter CW = 22,
    parameter SLOW_CYC = `HWC_LED_SLOW_CYC,
    parameter FAST_CYC = `HWC_LED_FAST_CYC
) (
    input wire clk_i,
    input wire rst_i,
    input wire activity_i,
    input wire fast_i,
    output reg led_o
);

    // ======================================================================
    // Phase timer
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_ON = 2'h1;
    localparam [1:0] ST_OFF = 2'h2;
    localparam integer SLOW_M1 = SLOW_CYC - 1;
    localparam integer FAST_M1 = FAST_CYC - 1;
    localparam [CW-1:0] SLOW_LOAD = SLOW_M1[CW-1:0];
    localparam [CW-1:0] FAST_LOAD = FAST_M1[CW-1:0];

    reg [1:0] state_ff;
    reg [CW-1:0] cnt_ff;
    reg pend_ff;
    wire [CW-1:0] load = fast_i ? FAST_LOAD : SLOW_LOAD;

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
            cnt_ff <= {CW{1'b0}};
            pend_ff <= 1'b0;
            led_o <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (activity_i || pend_ff) begin
                        state_ff <= ST_ON;
                        cnt_ff <= load;
                        pend_ff <= 1'b0;
                        led_o <= 1'b1;
                    end
                end
                ST_ON: begin
                    if (activity_i) begin
                        pend_ff <= 1'b1;
                    end
                    if (cnt_ff == {CW{1'b0}}) begin
                        state_ff <= ST_OFF;
                        cnt_ff <= load;
                        led_o <= 1'b0;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                ST_OFF: begin
                    if (activity_i) begin
                        pend_ff <= 1'b1;
                    end
                    if (cnt_ff == {CW{1'b0}}) begin
                        state_ff <= ST_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                    led_o <= 1'b0;
                end
            endcase
        end
    end

endmodule // hwc_led_timer

// ---- core/hwc_rx_offset.v ----
// Purpose: Inserts zero padding bytes ahead of the first byte of each packet.
// Assumes: The downstream writer takes one byte per cycle without stalling.
// Notes: The pad count is taken when the packet starts.
`include "hwc_defs.vh"

module hwc_rx_offset (
    input wire clk_i,
    input wire rst_i,
    input wire [1:0] offset_i,
    input wire in_valid_i,
    input wire [7:0] in_data_i,
    input wire in_sop_i,
    input wire in_eop_i,
    output reg in_ready_o,
    output reg out_valid_o,
    output reg [7:0] out_data_o,
    output reg out_sop_o,
    output reg out_eop_o
);

    // ======================================================================
    // Pad insertion
    reg first_ff;
    reg started_ff;
    reg [1:0] pad_cnt_ff;
    reg nxt_first;
    reg nxt_started;
    reg [1:0] nxt_pad_cnt;
    wire take = in_valid_i && in_ready_o;
    wire begin_pad = first_ff && !started_ff && in_valid_i && in_sop_i && !take;
    wire pad_emit = started_ff && (pad_cnt_ff != 2'h0);

    always @* begin
        nxt_first = first_ff;
        nxt_started = started_ff;
        nxt_pad_cnt = pad_cnt_ff;
        if (begin_pad) begin
            nxt_started = 1'b1;
            nxt_pad_cnt = offset_i;
        end else if (pad_emit) begin
            nxt_pad_cnt = pad_cnt_ff - 2'h1;
        end
        if (take) begin
            nxt_first = in_eop_i;
            nxt_started = 1'b0;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            first_ff <= 1'b1;
            started_ff <= 1'b0;
            pad_cnt_ff <= 2'h0;
            in_ready_o <= 1'b0;
            out_valid_o <= 1'b0;
            out_data_o <= 8'h00;
            out_sop_o <= 1'b0;
            out_eop_o <= 1'b0;
        end else begin
            first_ff <= nxt_first;
            started_ff <= nxt_started;
            pad_cnt_ff <= nxt_pad_cnt;
            // Ready is registered, so it is worked out from the next state.
            in_ready_o <= !nxt_first || (nxt_started && nxt_pad_cnt == 2'h0) ||
                (!nxt_started && offset_i == 2'h0);
            out_valid_o <= pad_emit || take;
            out_data_o <= pad_emit ? 8'h00 : in_data_i;
            out_sop_o <= (pad_emit && pad_cnt_ff == offset_i) ||
                (take && first_ff && !started_ff);
            out_eop_o <= take && in_eop_i;
        end
    end

endmodule // hwc_rx_offset

// ---- core/hwc_top.v ----
// Purpose: Upper fields of the hardware configuration register and their logic.
// Assumes: rst_i is power-on reset; dev_reset_i pulses for every other reset.
// Notes: Registers are reached over a classic Wishbone slave.
//
// Our own choices: register access over Wishbone and the placing of the registers.
`include "hwc_defs.vh"

// Functional notes
// - While the shield bit is set, the protected fields survive every reset but power-on.
// - The shield bit and the drive boost field are the protected fields here.
// - The boost code selects normal, +4, +8 or +12 percent high-speed drive.
// - A bulk IN token on an empty receive FIFO gets a ZLP when the reply bit is 0, else NAK.
// - The activity LED uses 80 ms on/off times, or about 15 us when the fast bit is set.
// - The offset field puts 0 to 3 zero bytes ahead of each receive packet.
// - A loss of sync stalls the bulk OUT pipe unless the stall-disable bit is 1.
// - In internal PHY mode the visibility bit drives the MII subset pins as outputs.
// - With an external PHY the visibility bit has no effect on the pins.
// - Active visibility overrides the normal pin function on those pins.
// - Errored frames are dropped when the drop bit is 1 and passed when it is 0.
// - Boost defaults to the loaded image or 00, and other resets restore that value while the shield bit is clear.
module hwc_top #(
    parameter LED_SLOW_CYC = `HWC_LED_SLOW_CYC,
    parameter LED_FAST_CYC = `HWC_LED_FAST_CYC,
    parameter LED_CW = 22,
    parameter NPIN = `HWC_MII_PINS
) (
    input wire clk_i,
    input wire rst_i,
    input wire dev_reset_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire eeprom_load_i,
    input wire eeprom_present_i,
    input wire [1:0] eeprom_boost_i,
    output reg [1:0] hs_drive_boost_o,
    output reg [3:0] hs_boost_pct_o,
    input wire bulk_in_token_i,
    input wire rx_fifo_empty_i,
    output reg bulk_in_zlp_o,
    output reg bulk_in_nak_o,
    input wire activity_i,
    output wire activity_led_o,
    input wire rx_in_valid_i,
    input wire [7:0] rx_in_data_i,
    input wire rx_in_sop_i,
    input wire rx_in_eop_i,
    output wire rx_in_ready_o,
    output wire rx_out_valid_o,
    output wire [7:0] rx_out_data_o,
    output wire rx_out_sop_o,
    output wire rx_out_eop_o,
    input wire loss_of_sync_i,
    input wire stall_clear_i,
    output reg bulk_out_stall_o,
    input wire phy_external_i,
    input wire [NPIN-1:0] mii_int_i,
    input wire [NPIN-1:0] pin_func_out_i,
    input wire [NPIN-1:0] pin_func_oe_i,
    output reg [NPIN-1:0] pin_o,
    output reg [NPIN-1:0] pin_oe_o,
    input wire rx_frame_end_i,
    input wire rx_frame_err_i,
    output reg rx_frame_drop_o,
    output reg rx_frame_pass_o
);

    // ======================================================================
    // Configuration fields
    reg prot_ff;
    reg [1:0] boost_ff;
    reg [1:0] image_ff;
    reg bir_ff;
    reg activity_led_fast_ff;
    reg [1:0] rxoff_ff;
    reg sbp_ff;
    reg ime_ff;
    reg drp_ff;
    reg [7:0] drop_cnt_ff;
    reg [1:0] nxt_boost;

    // ======================================================================
    // Bus decode
    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr_cfg = wb_req && wb_we_i && (wb_adr_i == `HWC_ADR_HARDWARE_CONFIGURATION);
    wire wr_hi = wr_cfg && wb_sel_i[1];
    wire wr_lo = wr_cfg && wb_sel_i[0];
    wire [1:0] eeprom_value = eeprom_present_i ? eeprom_boost_i : `HWC_BOOST_RST;
    wire vis_active = ime_ff && !phy_external_i;

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h00000000;
            if (wb_req && !wb_we_i) begin
                case (wb_adr_i)
                    `HWC_ADR_HARDWARE_CONFIGURATION: begin
                        wb_dat_o[`HWC_PROT_BIT] <= prot_ff;
                        wb_dat_o[`HWC_BOOST_HI:`HWC_BOOST_LO] <= boost_ff;
                        wb_dat_o[`HWC_BIR_BIT] <= bir_ff;
                        wb_dat_o[`HWC_ACTIVITY_LED_FAST_BIT] <= activity_led_fast_ff;
                        wb_dat_o[`HWC_RXOFF_HI:`HWC_RXOFF_LO] <= rxoff_ff;
                        wb_dat_o[`HWC_SBP_BIT] <= sbp_ff;
                        wb_dat_o[`HWC_IME_BIT] <= ime_ff;
                        wb_dat_o[`HWC_DRP_BIT] <= drp_ff;
                    end
                    `HWC_ADR_STATUS: begin
                        wb_dat_o[0] <= bulk_out_stall_o;
                        wb_dat_o[1] <= activity_led_o;
                        wb_dat_o[2] <= vis_active;
                        wb_dat_o[3] <= phy_external_i;
                        wb_dat_o[15:8] <= drop_cnt_ff;
                    end
                    default: begin
                        wb_dat_o <= 32'h00000000;
                    end
                endcase
            end
        end
    end

    // ======================================================================
    // Protected fields
    // A non-power-on reset outranks a write in the same cycle.
    always @* begin
        nxt_boost = boost_ff;
        if (eeprom_load_i && !prot_ff) begin
            nxt_boost = eeprom_value;
        end
        if (wr_hi) begin
            nxt_boost = wb_dat_i[`HWC_BOOST_HI:`HWC_BOOST_LO];
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            prot_ff <= `HWC_PROT_RST;
            boost_ff <= `HWC_BOOST_RST;
            image_ff <= `HWC_BOOST_RST;
        end else begin
            if (eeprom_load_i) begin
                image_ff <= eeprom_value;
            end
            if (dev_reset_i) begin
                if (!prot_ff) begin
                    boost_ff <= image_ff;
                end
            end else begin
                boost_ff <= nxt_boost;
                if (wr_hi) begin
                    prot_ff <= wb_dat_i[`HWC_PROT_BIT];
                end
            end
        end
    end

    // ======================================================================
    // Unprotected fields
    always @(posedge clk_i) begin
        if (rst_i || dev_reset_i) begin
            bir_ff <= `HWC_BIR_RST;
            activity_led_fast_ff <= `HWC_ACTIVITY_LED_FAST_RST;
            rxoff_ff <= `HWC_RXOFF_RST;
            sbp_ff <= `HWC_SBP_RST;
            ime_ff <= `HWC_IME_RST;
            drp_ff <= `HWC_DRP_RST;
        end else begin
            if (wr_hi) begin
                bir_ff <= wb_dat_i[`HWC_BIR_BIT];
                activity_led_fast_ff <= wb_dat_i[`HWC_ACTIVITY_LED_FAST_BIT];
                rxoff_ff <= wb_dat_i[`HWC_RXOFF_HI:`HWC_RXOFF_LO];
                sbp_ff <= wb_dat_i[`HWC_SBP_BIT];
            end
            if (wr_lo) begin
                ime_ff <= wb_dat_i[`HWC_IME_BIT];
                drp_ff <= wb_dat_i[`HWC_DRP_BIT];
            end
        end
    end

    // ======================================================================
    // Drive boost outputs
    always @(posedge clk_i) begin
        if (rst_i) begin
            hs_drive_boost_o <= `HWC_BOOST_RST;
            hs_boost_pct_o <= `HWC_BOOST_PCT0;
        end else begin
            hs_drive_boost_o <= boost_ff;
            case (boost_ff)
                2'h0: hs_boost_pct_o <= `HWC_BOOST_PCT0;
                2'h1: hs_boost_pct_o <= `HWC_BOOST_PCT1;
                2'h2: hs_boost_pct_o <= `HWC_BOOST_PCT2;
                default: hs_boost_pct_o <= `HWC_BOOST_PCT3;
            endcase
        end
    end

    // ======================================================================
    // USB pipe replies
    always @(posedge clk_i) begin
        if (rst_i || dev_reset_i) begin
            bulk_in_zlp_o <= 1'b0;
            bulk_in_nak_o <= 1'b0;
            bulk_out_stall_o <= 1'b0;
        end else begin
            bulk_in_zlp_o <= bulk_in_token_i && rx_fifo_empty_i && !bir_ff;
            bulk_in_nak_o <= bulk_in_token_i && rx_fifo_empty_i && bir_ff;
            // A new loss of sync in the clearing cycle keeps the pipe stalled.
            if (loss_of_sync_i && !sbp_ff) begin
                bulk_out_stall_o <= 1'b1;
            end else if (stall_clear_i) begin
                bulk_out_stall_o <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Pin multiplexing
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_o <= {NPIN{1'b0}};
            pin_oe_o <= {NPIN{1'b0}};
        end else if (vis_active) begin
            pin_o <= mii_int_i;
            pin_oe_o <= {NPIN{1'b1}};
        end else begin
            pin_o <= pin_func_out_i;
            pin_oe_o <= pin_func_oe_i;
        end
    end

    // ======================================================================
    // Receive frame filter
    // The drop counter saturates so software never sees it wrap.
    always @(posedge clk_i) begin
        if (rst_i || dev_reset_i) begin
            rx_frame_drop_o <= 1'b0;
            rx_frame_pass_o <= 1'b0;
            drop_cnt_ff <= 8'h00;
        end else begin
            rx_frame_drop_o <= rx_frame_end_i && rx_frame_err_i && drp_ff;
            rx_frame_pass_o <= rx_frame_end_i && !(rx_frame_err_i && drp_ff);
            if (rx_frame_end_i && rx_frame_err_i && drp_ff && drop_cnt_ff != 8'hFF) begin
                drop_cnt_ff <= drop_cnt_ff + 8'h01;
            end
        end
    end

    // ======================================================================
    // Activity LED and receive padding
    hwc_led_timer #(
        .CW(LED_CW),
        .SLOW_CYC(LED_SLOW_CYC),
        .FAST_CYC(LED_FAST_CYC)
    ) u_led (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .activity_i(activity_i),
        .fast_i(activity_led_fast_ff),
        .led_o(activity_led_o)
    );

    hwc_rx_offset u_rxoff (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .offset_i(rxoff_ff),
        .in_valid_i(rx_in_valid_i),
        .in_data_i(rx_in_data_i),
        .in_sop_i(rx_in_sop_i),
        .in_eop_i(rx_in_eop_i),
        .in_ready_o(rx_in_ready_o),
        .out_valid_o(rx_out_valid_o),
        .out_data_o(rx_out_data_o),
        .out_sop_o(rx_out_sop_o),
        .out_eop_o(rx_out_eop_o)
    );

endmodule // hwc_top

// ---- verif/hwc_checker.sv ----
// Purpose: Port-level assertions for the hardware configuration block.
// Assumes: One clock; rst_i and dev_reset_i both quiet the checks.
// Notes: Register fields are hidden here, so outputs are tied to causes at the ports.
module hwc_checker #(
    parameter NPIN = 9
) (
    input logic clk_i,
    input logic rst_i,
    input logic dev_reset_i,
    input logic bulk_in_token_i,
    input logic rx_fifo_empty_i,
    input logic bulk_in_zlp_o,
    input logic bulk_in_nak_o,
    input logic [1:0] hs_drive_boost_o,
    input logic [3:0] hs_boost_pct_o,
    input logic activity_led_o,
    input logic loss_of_sync_i,
    input logic bulk_out_stall_o,
    input logic phy_external_i,
    input logic [NPIN-1:0] mii_int_i,
    input logic [NPIN-1:0] pin_func_out_i,
    input logic [NPIN-1:0] pin_func_oe_i,
    input logic [NPIN-1:0] pin_o,
    input logic [NPIN-1:0] pin_oe_o,
    input logic rx_frame_end_i,
    input logic rx_frame_err_i,
    input logic rx_frame_drop_o,
    input logic rx_frame_pass_o
);
    // ====================
    // Checks
    // A device reset clears pulses, so it is treated like a reset for every check.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || dev_reset_i);

    property p_bulk_reply;
        bulk_in_token_i && rx_fifo_empty_i |=> bulk_in_zlp_o != bulk_in_nak_o;
    endproperty
    a_bulk_reply: assert property (p_bulk_reply) else $error("Empty FIFO reply wrong.");
    property p_bulk_busy;
        bulk_in_token_i && !rx_fifo_empty_i |=> !bulk_in_zlp_o && !bulk_in_nak_o;
    endproperty
    a_bulk_busy: assert property (p_bulk_busy) else $error("Busy FIFO got a reply.");
    property p_boost_pct;
        hs_boost_pct_o == {hs_drive_boost_o, 2'h0};
    endproperty
    a_boost_pct: assert property (p_boost_pct) else $error("Boost percent wrong.");
    property p_led_hold;
        $rose(activity_led_o) |-> activity_led_o [*8];
    endproperty
    a_led_hold: assert property (p_led_hold) else $error("LED on time too short.");
    property p_stall_cause;
        $rose(bulk_out_stall_o) |-> $past(loss_of_sync_i);
    endproperty
    a_stall_cause: assert property (p_stall_cause) else $error("Stall without cause.");
    property p_pin_ext;
        !$past(rst_i) && $past(phy_external_i) |->
            pin_o == $past(pin_func_out_i) && pin_oe_o == $past(pin_func_oe_i);
    endproperty
    a_pin_ext: assert property (p_pin_ext) else $error("External PHY pins wrong.");
    property p_pin_int;
        !$past(rst_i) && !$past(phy_external_i) |->
            (pin_o == $past(pin_func_out_i) && pin_oe_o == $past(pin_func_oe_i))
            || (&pin_oe_o && pin_o == $past(mii_int_i));
    endproperty
    a_pin_int: assert property (p_pin_int) else $error("Internal PHY pins wrong.");
    property p_frame_ok;
        rx_frame_end_i && !rx_frame_err_i |=> rx_frame_pass_o && !rx_frame_drop_o;
    endproperty
    a_frame_ok: assert property (p_frame_ok) else $error("Good frame not passed.");
endmodule // hwc_checker

bind hwc_top hwc_checker #(.NPIN(NPIN)) i_hwc_checker (.*);

// ---- verif/hwc_tb_top.sv ----
// Purpose: Self-checking bench for the hardware configuration block.
// Assumes: Short LED counts; rst_i acts as power-on reset.
// Notes: An integer model tracks the register, the boost image and the drop count.
module hwc_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SLOW = 200;
    localparam int FAST = 20;
    logic clk_i, rst_i, dev_reset_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, eeprom_load_i;
    logic eeprom_present_i, bulk_in_token_i, rx_fifo_empty_i, bulk_in_zlp_o, bulk_in_nak_o;
    logic activity_i, activity_led_o, rx_in_valid_i, rx_in_sop_i, rx_in_eop_i, rx_in_ready_o;
    logic rx_out_valid_o, rx_out_sop_o, rx_out_eop_o, loss_of_sync_i, stall_clear_i;
    logic bulk_out_stall_o, phy_external_i, rx_frame_end_i, rx_frame_err_i, rx_frame_drop_o;
    logic rx_frame_pass_o;
    logic [1:0] eeprom_boost_i, hs_drive_boost_o;
    logic [3:0] wb_sel_i, hs_boost_pct_o;
    logic [7:0] wb_adr_i, rx_in_data_i, rx_out_data_o;
    logic [8:0] mii_int_i, pin_func_out_i, pin_func_oe_i, pin_o, pin_oe_o;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [8:0] got_q[$];
    logic [8:0] exp_q[$];
    int num_errors, checked, seed, m_cfg, m_img, m_drops, k, t, v;

    hwc_top #(.LED_SLOW_CYC(SLOW), .LED_FAST_CYC(FAST)) i_hwc_top (.*);

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (rx_out_valid_o === 1'b1) got_q.push_back({rx_out_sop_o, rx_out_data_o});
    end

    // ====================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("Checked %0d, errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic await(ref logic s);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (s !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            results();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        await(wb_ack_o);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (w && a == 8'h14) m_cfg = d & 32'hFFC0;
    endtask
    task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic pulse(input int s);
        @(posedge clk_i);
        loss_of_sync_i <= (s == 0);
        stall_clear_i <= (s == 1);
        activity_i <= (s == 2);
        eeprom_load_i <= (s == 3);
        dev_reset_i <= (s == 4);
        bulk_in_token_i <= (s == 5);
        rx_frame_end_i <= (s == 6);
        @(posedge clk_i);
        {loss_of_sync_i, stall_clear_i, activity_i, eeprom_load_i} <= 4'h0;
        {dev_reset_i, bulk_in_token_i, rx_frame_end_i} <= 3'h0;
        if (s == 4 && m_cfg[15]) m_cfg = m_cfg & 32'hE000;
        else if (s == 4) m_cfg = m_img << 13;
        if (s == 4) m_drops = 0;
    endtask
    task automatic rx_byte(input logic [7:0] d, input logic s, input logic e);
        @(posedge clk_i);
        rx_in_valid_i <= 1'b1;
        rx_in_data_i <= d;
        rx_in_sop_i <= s;
        rx_in_eop_i <= e;
        await(rx_in_ready_o);
        rx_in_valid_i <= 1'b0;
    endtask

    // ====================
    // Main sequence
    initial begin
        seed = 8;
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, eeprom_load_i, eeprom_present_i, activity_i} = 6'h0;
        {bulk_in_token_i, rx_fifo_empty_i, rx_in_valid_i, rx_in_sop_i, rx_in_eop_i} = 5'h0;
        {loss_of_sync_i, stall_clear_i, phy_external_i, rx_frame_end_i} = 4'h0;
        {rx_frame_err_i, dev_reset_i, eeprom_boost_i, wb_sel_i, wb_adr_i, rx_in_data_i} = 24'h0;
        {mii_int_i, pin_func_out_i, pin_func_oe_i, wb_dat_i} = 59'h0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_exp(8'h14, 32'h0);
        bus(1'b1, 8'h80, 32'hFFFFFFFF);
        bus(1'b1, 8'h40, 32'hFFFFFFFF);
        rd_exp(8'h80, 32'h0);
        rd_exp(8'h40, 32'h0);
        for (k = 0; k < 4; k++) begin
            bus(1'b1, 8'h14, k << 13);
            repeat (2) @(posedge clk_i);
            chk({hs_drive_boost_o, hs_boost_pct_o}, {k[1:0], k[1:0], 2'h0});
        end
        for (k = 0; k < 2; k++) begin
            bus(1'b1, 8'h14, k << 12);
            rx_fifo_empty_i <= 1'b1;
            pulse(5);
            @(posedge clk_i);
            chk({bulk_in_zlp_o, bulk_in_nak_o}, {k == 0, k == 1});
            rx_fifo_empty_i <= 1'b0;
            pulse(5);
            @(posedge clk_i);
            chk({bulk_in_zlp_o, bulk_in_nak_o}, 2'h0);
        end
        bus(1'b1, 8'h14, 32'h5FC0);
        eeprom_present_i <= 1'b1;
        eeprom_boost_i <= 2'h3;
        pulse(3);
        m_img = 3;
        m_cfg = 32'h7FC0;
        rd_exp(8'h14, m_cfg);
        pulse(4);
        rd_exp(8'h14, m_cfg);
        bus(1'b1, 8'h14, 32'hBFC0);
        pulse(4);
        rd_exp(8'h14, m_cfg);
        eeprom_present_i <= 1'b0;
        pulse(3);
        m_img = 0;
        rd_exp(8'h14, m_cfg);
        chk(hs_drive_boost_o, 2'h1);
        @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        m_cfg = 0;
        m_drops = 0;
        rd_exp(8'h14, 32'h0);
        bus(1'b1, 8'h14, 32'h0);
        pulse(0);
        @(posedge clk_i);
        rd_exp(8'h40, 32'h1);
        pulse(1);
        @(posedge clk_i);
        chk(bulk_out_stall_o, 1'h0);
        bus(1'b1, 8'h14, 32'h100);
        pulse(0);
        @(posedge clk_i);
        chk(bulk_out_stall_o, 1'h0);
        for (k = 0; k < 4; k++) begin
            bus(1'b1, 8'h14, {k[1], 6'h0});
            rx_frame_err_i <= k[0];
            pulse(6);
            @(posedge clk_i);
            v = k[0] & k[1];
            m_drops += v;
            chk({rx_frame_drop_o, rx_frame_pass_o}, {v[0], !v[0]});
        end
        rd_exp(8'h40, m_drops << 8);
        for (k = 0; k < 4; k++) begin
            bus(1'b1, 8'h14, {k[0], 7'h0});
            phy_external_i <= k[1];
            mii_int_i <= 9'($random(seed));
            pin_func_out_i <= 9'($random(seed));
            pin_func_oe_i <= 9'($random(seed));
            repeat (2) @(posedge clk_i);
            v = k[0] & !k[1];
            if (v) chk({pin_o, pin_oe_o}, {mii_int_i, 9'h1FF});
            else chk({pin_o, pin_oe_o}, {pin_func_out_i, pin_func_oe_i});
            rd_exp(8'h40, (m_drops << 8) | {k[1], v[0], 2'h0});
        end
        for (k = 0; k < 4; k++) begin
            bus(1'b1, 8'h14, {k[1:0], 9'h0});
            got_q.delete();
            exp_q.delete();
            for (t = 0; t < k; t++) exp_q.push_back({t == 0, 8'h00});
            exp_q.push_back({k == 0, 8'hA0});
            exp_q.push_back({1'b0, 8'h5B});
            rx_byte(8'hA0, 1'b1, 1'b0);
            rx_byte(8'h5B, 1'b0, 1'b1);
            repeat (4) @(posedge clk_i);
            chk(got_q.size(), exp_q.size());
            for (t = 0; t < exp_q.size(); t++) chk(got_q[t], exp_q[t]);
        end
        // Each blink is timed from its rise, so the off phase is waited out in full.
        for (k = 0; k < 2; k++) begin
            bus(1'b1, 8'h14, {k[0], 11'h0});
            pulse(2);
            await(activity_led_o);
            t = 0;
            do begin
                @(posedge clk_i);
                t++;
            end while (activity_led_o === 1'b1 && t < 1000);
            chk(t, k ? FAST : SLOW);
            repeat (SLOW + 10) @(posedge clk_i);
        end
        results();
    end
endmodule // hwc_tb_top
